// [pio_pkg.sv]
// constants, state layout and decode helpers for the parallel port bank
// assumes one bus clock and a plain single-cycle register port
package pio_pkg;

  localparam int unsigned NUM_PINS  = 54;
  localparam int unsigned NUM_PORTS = 7;
  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned DATA_W    = 8;

  // address layout: {port[2:0], reg[2:0]}
  localparam int unsigned ADDR_PORT_LSB = 3;
  localparam logic [2:0]  REG_DATA      = 3'h0;
  localparam logic [2:0]  REG_DIR       = 3'h1;
  localparam logic [2:0]  REG_PULL      = 3'h2;
  localparam logic [2:0]  REG_SLEW      = 3'h3;
  localparam logic [2:0]  REG_DRIVE     = 3'h4;

  // reset values per pin
  localparam logic RST_DATA  = 1'b0;
  localparam logic RST_DIR   = 1'b0;
  localparam logic RST_PULL  = 1'b0;
  localparam logic RST_SLEW  = 1'b1;
  localparam logic RST_DRIVE = 1'b0;

  // port g placement and its oscillator pins
  localparam int unsigned PORT_G_BASE = 47;
  localparam int unsigned PORT_G_W    = 7;
  localparam int unsigned OSC_PIN_A   = 52;
  localparam int unsigned OSC_PIN_B   = 53;

  typedef struct packed {
    logic [NUM_PINS-1:0] dat;
    logic [NUM_PINS-1:0] dir;
    logic [NUM_PINS-1:0] pull;
    logic [NUM_PINS-1:0] slew;
    logic [NUM_PINS-1:0] drive;
    logic [DATA_W-1:0]   rdata;
  } pio_state_t;

  // ports a..g hold 8,8,7,8,8,8,7 pins
  function automatic int unsigned pio_port_w(input logic [2:0] p);
    case (p)
      3'h2, 3'h6: pio_port_w = 7;
      3'h7:       pio_port_w = 0;
      default:    pio_port_w = 8;
    endcase
  endfunction : pio_port_w

  function automatic int unsigned pio_port_base(input logic [2:0] p);
    case (p)
      3'h0:    pio_port_base = 0;
      3'h1:    pio_port_base = 8;
      3'h2:    pio_port_base = 16;
      3'h3:    pio_port_base = 23;
      3'h4:    pio_port_base = 31;
      3'h5:    pio_port_base = 39;
      3'h6:    pio_port_base = PORT_G_BASE;
      default: pio_port_base = 0;
    endcase
  endfunction : pio_port_base

endpackage : pio_pkg

// [pio_pin_sync.sv]
// two-stage synchroniser for the raw pin levels
// assumes pin levels arrive asynchronously to the bus clock
`timescale 1ns/1ps
module pio_pin_sync
  import pio_pkg::*;
(
  // clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_arst_n,
  // levels
  input  wire logic [NUM_PINS-1:0] i_raw,
  output logic      [NUM_PINS-1:0] o_sync
);

  typedef struct packed {
    logic [NUM_PINS-1:0] s1;
    logic [NUM_PINS-1:0] s2;
  } pio_sync_t;

  pio_sync_t st_q;
  pio_sync_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = i_raw;
    // first stage feeds only the second
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.s2;

endmodule : pio_pin_sync

// [pio_pin_owner.sv]
// per-pin ownership and pad control, purely combinational
// assumes peripheral enables come from logic on the bus clock
`timescale 1ns/1ps
module pio_pin_owner
  import pio_pkg::*;
(
  // port registers
  input  wire logic i_dir,
  input  wire logic i_dat,
  input  wire logic i_pull,
  input  wire logic i_slew,
  input  wire logic i_drive,
  // shared functions
  input  wire logic i_periph_en,
  input  wire logic i_periph_oe,
  input  wire logic i_periph_out,
  input  wire logic i_analog_en,
  input  wire logic i_force_in,
  input  wire logic i_osc_en,
  // pad controls
  output logic      o_oe_n,
  output logic      o_out,
  output logic      o_pull,
  output logic      o_slew,
  output logic      o_drive_hi
);

  logic drv;

  always_comb begin
    drv = 1'b0;
    if (i_analog_en || i_osc_en) begin
      drv = 1'b0;
    end else if (i_force_in) begin
      drv = 1'b0;
    end else if (i_periph_en) begin
      drv = i_periph_oe;
    end else begin
      drv = i_dir;
    end
    o_oe_n     = ~drv;
    o_out      = i_periph_en ? i_periph_out : i_dat;
    o_pull     = i_pull & ~drv & ~i_analog_en & ~i_osc_en;
    o_slew     = i_slew & drv;
    o_drive_hi = i_drive & drv;
  end

endmodule : pio_pin_owner

// [pio_port_bank.sv]
// seven-port, 54-pin parallel io bank with pad control and pin arbitration
// assumes a single-cycle register port on the bus clock; pins are async
// What this block does
// - 54 pins in seven ports, plain io
// - reset leaves every pin owned by io
// - reset clears all direction bits
// - reset: slew on, low drive, pullups off
// - direction low: driver off, read pin
// - direction high: drive pin, read latch
// - direction still picks read source under peripheral
// - enabled peripheral decides pin direction
// - peripheral output level replaces data latch
// - analog function disables all digital functions
// - analog pins read as zero
// - analog beats digital peripheral
// - converter beats keyboard interrupt on shared pins
// - keyboard interrupt pin always input
// - oscillator takes both oscillator pins
// - pin controls independent of data, direction
// - pullup bit enables pullup
// - any output forces pullup off
// - analog control forces pullup off
// - data writes latch regardless of direction
// - slew limit only on outputs
// - drive bit selects high drive
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module pio_port_bank
  import pio_pkg::*;
(
  // clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_arst_n,
  // register port
  input  wire logic [ADDR_W-1:0]   i_addr,
  input  wire logic [DATA_W-1:0]   i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [DATA_W-1:0]   o_rdata,
  // shared digital peripherals, one bit per pin
  input  wire logic [NUM_PINS-1:0] i_periph_en,
  input  wire logic [NUM_PINS-1:0] i_periph_oe,
  input  wire logic [NUM_PINS-1:0] i_periph_out,
  // analog converter inputs, one bit per pin
  input  wire logic [NUM_PINS-1:0] i_analog_en,
  // keyboard interrupt on port g and oscillator enable
  input  wire logic [PORT_G_W-1:0] i_kbi_en,
  input  wire logic                i_osc_en,
  // pads
  input  wire logic [NUM_PINS-1:0] i_pin,
  output logic      [NUM_PINS-1:0] o_pin,
  output logic      [NUM_PINS-1:0] o_pin_oe_n,
  output logic      [NUM_PINS-1:0] o_pullup_en,
  output logic      [NUM_PINS-1:0] o_slew_en,
  output logic      [NUM_PINS-1:0] o_drive_hi
);

  pio_state_t          st_q;
  pio_state_t          st_d;
  logic [NUM_PINS-1:0] pin_s;
  logic [NUM_PINS-1:0] data_rd;
  logic [NUM_PINS-1:0] force_in;
  logic [NUM_PINS-1:0] osc_sel;
  logic [2:0]          a_port;
  logic [2:0]          a_reg;
  logic                a_hit;

  // write one port's bits into a flat pin vector; missing bits ignored
  function automatic logic [NUM_PINS-1:0] put_port(input logic [NUM_PINS-1:0] v,
                                                   input logic [2:0]          p,
                                                   input logic [DATA_W-1:0]   w);
    logic [NUM_PINS-1:0] r;
    int unsigned         b;
    int unsigned         n;
    r = v;
    b = pio_port_base(p);
    n = pio_port_w(p);
    for (int unsigned i = 0; i < DATA_W; i++) begin
      if (i < n) begin
        r[b+i] = w[i];
      end
    end
    return r;
  endfunction : put_port

  // gather one port's bits; absent bit positions read as zero
  function automatic logic [DATA_W-1:0] get_port(input logic [NUM_PINS-1:0] v,
                                                 input logic [2:0]          p);
    logic [DATA_W-1:0] r;
    int unsigned       b;
    int unsigned       n;
    r = '0;
    b = pio_port_base(p);
    n = pio_port_w(p);
    for (int unsigned i = 0; i < DATA_W; i++) begin
      if (i < n) begin
        r[i] = v[b+i];
      end
    end
    return r;
  endfunction : get_port

  assign a_port = i_addr[ADDR_W-1:ADDR_PORT_LSB];
  assign a_reg  = i_addr[ADDR_PORT_LSB-1:0];
  assign a_hit  = (pio_port_w(a_port) != 0) && (a_reg <= REG_DRIVE);

  // pin levels cross into the bus clock before any read logic
  pio_pin_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_raw     (i_pin),
    .o_sync    (pin_s)
  );

  // keyboard interrupt only exists on port g; oscillator on two g pins
  always_comb begin
    force_in = '0;
    osc_sel  = '0;
    force_in[PORT_G_BASE +: PORT_G_W] = i_kbi_en;
    osc_sel[OSC_PIN_A] = i_osc_en;
    osc_sel[OSC_PIN_B] = i_osc_en;
  end

  // read source follows the direction bit even under a peripheral
  assign data_rd = ~i_analog_en & ((st_q.dir & st_q.dat) | (~st_q.dir & pin_s));

  generate
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      pio_pin_owner u_own (
        .i_dir        (st_q.dir[g]),
        .i_dat        (st_q.dat[g]),
        .i_pull       (st_q.pull[g]),
        .i_slew       (st_q.slew[g]),
        .i_drive      (st_q.drive[g]),
        .i_periph_en  (i_periph_en[g]),
        .i_periph_oe  (i_periph_oe[g]),
        .i_periph_out (i_periph_out[g]),
        .i_analog_en  (i_analog_en[g]),
        .i_force_in   (force_in[g]),
        .i_osc_en     (osc_sel[g]),
        .o_oe_n       (o_pin_oe_n[g]),
        .o_out        (o_pin[g]),
        .o_pull       (o_pullup_en[g]),
        .o_slew       (o_slew_en[g]),
        .o_drive_hi   (o_drive_hi[g])
      );
    end
  endgenerate

  always_comb begin
    st_d       = st_q;
    st_d.rdata = '0;
    if (i_wr && a_hit) begin
      case (a_reg)
        REG_DATA:  st_d.dat   = put_port(st_q.dat, a_port, i_wdata);
        REG_DIR:   st_d.dir   = put_port(st_q.dir, a_port, i_wdata);
        REG_PULL:  st_d.pull  = put_port(st_q.pull, a_port, i_wdata);
        REG_SLEW:  st_d.slew  = put_port(st_q.slew, a_port, i_wdata);
        REG_DRIVE: st_d.drive = put_port(st_q.drive, a_port, i_wdata);
        default:   st_d.dat   = st_q.dat;
      endcase
    end
    // unmapped reads answer zero; data stands one cycle only
    if (i_rd && a_hit) begin
      case (a_reg)
        REG_DATA:  st_d.rdata = get_port(data_rd, a_port);
        REG_DIR:   st_d.rdata = get_port(st_q.dir, a_port);
        REG_PULL:  st_d.rdata = get_port(st_q.pull, a_port);
        REG_SLEW:  st_d.rdata = get_port(st_q.slew, a_port);
        REG_DRIVE: st_d.rdata = get_port(st_q.drive, a_port);
        default:   st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q.dat   <= {NUM_PINS{RST_DATA}};
      st_q.dir   <= {NUM_PINS{RST_DIR}};
      st_q.pull  <= {NUM_PINS{RST_PULL}};
      st_q.slew  <= {NUM_PINS{RST_SLEW}};
      st_q.drive <= {NUM_PINS{RST_DRIVE}};
      st_q.rdata <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;

  // checks on the bank's own outputs and register state
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_wr_port_a_data;
    i_wr && (i_addr == {3'h0, REG_DATA});
  endsequence

  sequence s_rd_port_a_data;
    i_rd && (i_addr == {3'h0, REG_DATA});
  endsequence

  property p_rd_unmapped;
    (i_rd && !a_hit) |=> (o_rdata == '0);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_wr_latch;
    s_wr_port_a_data |=> (st_q.dat[7:0] == $past(i_wdata));
  endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("data write not latched");

  property p_rd_latch;
    s_rd_port_a_data ##0 (st_q.dir[7:0] == 8'hff) ##0 (i_analog_en[7:0] == 8'h00)
      |=> (o_rdata == $past(st_q.dat[7:0]));
  endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("output read not latch");

  property p_rd_pin;
    s_rd_port_a_data ##0 (st_q.dir[7:0] == 8'h00) ##0 (i_analog_en[7:0] == 8'h00)
      |=> (o_rdata == $past(pin_s[7:0]));
  endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("input read not pin level");

  property p_rd_analog_zero;
    s_rd_port_a_data |=> ((o_rdata & $past(i_analog_en[7:0])) == 8'h00);
  endproperty
  a_rd_analog_zero: assert property (p_rd_analog_zero) else $error("analog bit read nonzero");

  property p_analog_owns;
    (i_analog_en & ~o_pin_oe_n) == '0 && (i_analog_en & o_pullup_en) == '0;
  endproperty
  a_analog_owns: assert property (p_analog_owns) else $error("analog pin has digital drive");

  property p_pull_off_out;
    (~o_pin_oe_n & o_pullup_en) == '0;
  endproperty
  a_pull_off_out: assert property (p_pull_off_out) else $error("pullup on driven pin");

  property p_slew_in;
    (o_pin_oe_n & (o_slew_en | o_drive_hi)) == '0;
  endproperty
  a_slew_in: assert property (p_slew_in) else $error("slew or drive on input");

  property p_kbi_input;
    (i_kbi_en != '0) |-> ((i_kbi_en & ~o_pin_oe_n[PORT_G_BASE +: PORT_G_W]) == '0);
  endproperty
  a_kbi_input: assert property (p_kbi_input) else $error("keyboard pin driven");

  property p_osc_pins;
    i_osc_en |-> (o_pin_oe_n[OSC_PIN_B:OSC_PIN_A] == 2'h3) && (o_pullup_en[OSC_PIN_B:OSC_PIN_A] == 2'h0);
  endproperty
  a_osc_pins: assert property (p_osc_pins) else $error("oscillator pin still controlled");

  property p_ctrl_indep;
    (i_wr && a_hit && (a_reg >= REG_PULL)) |=> $stable(st_q.dat) && $stable(st_q.dir);
  endproperty
  a_ctrl_indep: assert property (p_ctrl_indep) else $error("pin control write hit data");

  property p_periph_drive;
    (i_periph_en[31] && i_periph_oe[31] && !i_analog_en[31]) |-> (!o_pin_oe_n[31] && o_pin[31] == i_periph_out[31]);
  endproperty
  a_periph_drive: assert property (p_periph_drive) else $error("peripheral output not driven");

  sequence s_wr_port_b_dir;
    i_wr && (i_addr == {3'h1, REG_DIR});
  endsequence

  sequence s_rd_port_a_dir;
    i_rd && (i_addr == {3'h0, REG_DIR});
  endsequence

  sequence s_rd_port_e_data;
    i_rd && (i_addr == {3'h4, REG_DATA});
  endsequence

  // first sampled edge after release still shows reset contents
  property p_rst_vals;
    !$past(i_arst_n) |-> (st_q.dir == '0) && (st_q.dat == '0) && (st_q.pull == '0) && (st_q.drive == '0)
      && (st_q.slew == '1);
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");

  property p_rst_own;
    !$past(i_arst_n) && (i_periph_en == '0) && (i_analog_en == '0) && (i_kbi_en == '0) && !i_osc_en
      |-> (o_pin_oe_n == '1) && (o_pullup_en == '0);
  endproperty
  a_rst_own: assert property (p_rst_own) else $error("pin not owned by io after reset");

  property p_dir_in;
    (~st_q.dir & ~i_periph_en & ~o_pin_oe_n) == '0;
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("input pin driven");

  property p_io_out;
    (~i_periph_en & ~o_pin_oe_n & (o_pin ^ st_q.dat)) == '0;
  endproperty
  a_io_out: assert property (p_io_out) else $error("driven io pin not latch level");

  // every pin, not just the one sampled above
  property p_periph_val;
    (i_periph_en & ~o_pin_oe_n & (o_pin ^ i_periph_out)) == '0;
  endproperty
  a_periph_val: assert property (p_periph_val) else $error("peripheral level not on pin");

  property p_analog_beats;
    (i_analog_en & i_periph_en & i_periph_oe & ~o_pin_oe_n) == '0;
  endproperty
  a_analog_beats: assert property (p_analog_beats) else $error("peripheral beat analog");

  property p_pull_on;
    o_pullup_en == (st_q.pull & o_pin_oe_n & ~i_analog_en & ~osc_sel);
  endproperty
  a_pull_on: assert property (p_pull_on) else $error("pullup not per enable bit");

  property p_slew_out;
    o_slew_en == (st_q.slew & ~o_pin_oe_n);
  endproperty
  a_slew_out: assert property (p_slew_out) else $error("slew limit not on output");

  property p_drive_sel;
    o_drive_hi == (st_q.drive & ~o_pin_oe_n);
  endproperty
  a_drive_sel: assert property (p_drive_sel) else $error("drive bit not applied");

  property p_osc_ctrl;
    i_osc_en |-> (o_slew_en[OSC_PIN_B:OSC_PIN_A] == 2'h0) && (o_drive_hi[OSC_PIN_B:OSC_PIN_A] == 2'h0);
  endproperty
  a_osc_ctrl: assert property (p_osc_ctrl) else $error("oscillator pin pad control active");

  // read data must not linger into the next cycle
  property p_rdata_one;
    !i_rd |=> (o_rdata == '0);
  endproperty
  a_rdata_one: assert property (p_rdata_one) else $error("read data stood too long");

  property p_wr_next;
    s_wr_port_b_dir |=> (st_q.dir[15:8] == $past(i_wdata));
  endproperty
  a_wr_next: assert property (p_wr_next) else $error("direction write not next edge");

  property p_rd_dir;
    s_rd_port_a_dir |=> (o_rdata == $past(st_q.dir[7:0]));
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("direction read wrong");

  // port c is seven wide, so its writes stop short of port d
  property p_port_edge;
    (i_wr && (i_addr == {3'h2, REG_DATA})) |=> $stable(st_q.dat[23]);
  endproperty
  a_port_edge: assert property (p_port_edge) else $error("port c write spilled over");

  property p_rd_periph_latch;
    s_rd_port_e_data ##0 st_q.dir[31] ##0 !i_analog_en[31] |=> (o_rdata[0] == $past(st_q.dat[31]));
  endproperty
  a_rd_periph_latch: assert property (p_rd_periph_latch) else $error("direction not picking read source");

endmodule : pio_port_bank

// [pio_board.sv]
// board model for the port bank pads
// assumes each released pad is held by a board strap set by the bench
`timescale 1ns/1ps
module pio_board
  import pio_pkg::*;
(
  // pads from the bank
  input  wire logic [NUM_PINS-1:0] i_pin_out,
  input  wire logic [NUM_PINS-1:0] i_pin_oe_n,
  // strap levels
  input  wire logic [NUM_PINS-1:0] i_strap,
  // resolved wire levels
  output logic      [NUM_PINS-1:0] o_level
);
  // straps are stiffer than the on-chip pullup, so a released pad reads the strap
  assign o_level = (i_pin_oe_n & i_strap) | (~i_pin_oe_n & i_pin_out);
endmodule : pio_board

// [pio_port_bank_tb_top.sv]
// self-checking bench for the parallel port bank
// assumes one 250 MHz clock and the board model on the pads
`timescale 1ns/1ps
module pio_port_bank_tb_top
  import pio_pkg::*;
;
  logic                i_ref_clk, i_arst_n, i_wr, i_rd, i_osc_en;
  logic [ADDR_W-1:0]   i_addr;
  logic [DATA_W-1:0]   i_wdata, o_rdata;
  logic [PORT_G_W-1:0] i_kbi_en;
  logic [NUM_PINS-1:0] i_periph_en, i_periph_oe, i_periph_out, i_analog_en, i_pin, strap;
  logic [NUM_PINS-1:0] o_pin, o_pin_oe_n, o_pullup_en, o_slew_en, o_drive_hi;
  logic [NUM_PINS-1:0] s_dat, s_dir, s_pull, s_slew, s_hi, e_drv, e_out, e_lvl, e_an;
  logic [31:0]         seed;
  int                  miscompares, compares;
  int                  base[8] = '{0, 8, 16, 23, 31, 39, 47, 0};
  int                  wid[8]  = '{8, 8, 7, 8, 8, 8, 7, 0};

  pio_port_bank i_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_periph_en(i_periph_en), .i_periph_oe(i_periph_oe),
    .i_periph_out(i_periph_out), .i_analog_en(i_analog_en), .i_kbi_en(i_kbi_en), .i_osc_en(i_osc_en),
    .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .o_pullup_en(o_pullup_en),
    .o_slew_en(o_slew_en), .o_drive_hi(o_drive_hi));
  pio_board i_board (.i_pin_out(o_pin), .i_pin_oe_n(o_pin_oe_n), .i_strap(strap), .o_level(i_pin));

  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [NUM_PINS-1:0] r54();
    logic [63:0] t;
    t = {rnd(), rnd()};
    return t[NUM_PINS-1:0];
  endfunction : r54

  // priority: analog/osc, then keyboard, then peripheral, then direction
  function automatic void calc();
    logic kb;
    for (int i = 0; i < NUM_PINS; i++) begin
      e_an[i] = i_analog_en[i] | (i_osc_en & (i >= OSC_PIN_A));
      kb = (i >= PORT_G_BASE) && i_kbi_en[(i - PORT_G_BASE) % PORT_G_W];
      e_drv[i] = !e_an[i] && !kb && (i_periph_en[i] ? i_periph_oe[i] : s_dir[i]);
      e_out[i] = i_periph_en[i] ? i_periph_out[i] : s_dat[i];
      e_lvl[i] = e_drv[i] ? e_out[i] : strap[i];
    end
  endfunction : calc

  function automatic logic [7:0] exp_reg(input int p, input int r);
    logic [NUM_PINS-1:0] src;
    logic [7:0]          v;
    v = 8'h00;
    case (r)
      0: src = ~i_analog_en & ((s_dir & s_dat) | (~s_dir & e_lvl));
      1: src = s_dir;
      2: src = s_pull;
      3: src = s_slew;
      4: src = s_hi;
      default: src = '0;
    endcase
    for (int b = 0; b < wid[p]; b++) begin
      v[b] = src[base[p] + b];
    end
    return v;
  endfunction : exp_reg

  task automatic cmp8(input int a, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH rdata at %0d expected %h seen %h", a, e, s);
    end
  endtask : cmp8

  task automatic cmp54(input string n, input logic [NUM_PINS-1:0] e, input logic [NUM_PINS-1:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : cmp54

  task automatic wr(input int p, input int r, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= 6'(p * 8 + r);
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    for (int b = 0; b < wid[p]; b++) begin
      case (r)
        0: s_dat[base[p] + b] = d[b];
        1: s_dir[base[p] + b] = d[b];
        2: s_pull[base[p] + b] = d[b];
        3: s_slew[base[p] + b] = d[b];
        4: s_hi[base[p] + b] = d[b];
        default: ;
      endcase
    end
  endtask : wr

  task automatic rdchk(input int p, input int r);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= 6'(p * 8 + r);
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    cmp8(p * 8 + r, exp_reg(p, r), o_rdata);
  endtask : rdchk

  task automatic padchk();
    calc();
    cmp54("oe_n", ~e_drv, o_pin_oe_n);
    cmp54("out", e_out & e_drv, o_pin & e_drv);
    cmp54("pullup", s_pull & ~e_drv & ~e_an, o_pullup_en);
    cmp54("slew", s_slew & e_drv, o_slew_en);
    cmp54("drive", s_hi & e_drv, o_drive_hi);
  endtask : padchk

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (100000) @(posedge i_ref_clk);
    miscompares++;
    results();
  end

  initial begin
    seed = 32'hb402;
    {i_wr, i_rd, i_osc_en, i_addr, i_wdata, i_kbi_en} = '0;
    {i_periph_en, i_periph_oe, i_periph_out, i_analog_en} = '0;
    strap = r54();
    {s_dat, s_dir, s_pull, s_hi} = '0;
    s_slew = '1;
    i_arst_n = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1;
    padchk();
    for (int a = 0; a < 64; a++) begin
      rdchk(a / 8, a % 8);
    end
    $display("test reset done");
    // corners: latch readback, analog over peripheral, keyboard over direction
    wr(0, 0, 8'h5a);
    wr(0, 1, 8'hff);
    #1;
    padchk();
    rdchk(0, 0);
    @(posedge i_ref_clk);
    i_analog_en <= 54'hf;
    i_periph_en <= 54'h3c;
    i_periph_oe <= '1;
    i_kbi_en <= 7'h7f;
    wr(6, 1, 8'h7f);
    repeat (3) @(posedge i_ref_clk);
    #1;
    padchk();
    rdchk(0, 0);
    rdchk(6, 0);
    $display("test corner done");
    for (int n = 0; n < 40; n++) begin
      @(posedge i_ref_clk);
      i_periph_en <= (n < 10) ? '0 : r54() & r54();
      i_periph_oe <= r54();
      i_periph_out <= r54();
      i_analog_en <= (n < 10) ? '0 : r54() & r54() & r54();
      i_kbi_en <= PORT_G_W'(rnd());
      i_osc_en <= 1'(rnd());
      strap <= r54();
      // data goes in ahead of direction so no stale level is driven
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int r = 0; r < 5; r++) begin
          wr(p, r, 8'(rnd()));
        end
      end
      #1;
      padchk();
      repeat (3) @(posedge i_ref_clk);
      for (int p = 0; p < NUM_PORTS; p++) begin
        for (int r = 0; r < 5; r++) begin
          rdchk(p, r);
        end
      end
    end
    $display("test random done");
    results();
  end
endmodule : pio_port_bank_tb_top
